// File: media_maint.sv
// Background media maintenance: idle-time scan scheduler, early-life
// write verify, deferred reallocation, idle write recheck, guard format.
// Assumes command and media strobes come from logic on pclk; APB slave.
//
// Our own choices: the register addresses and the APB interface to the registers.
`include "media_maint_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module media_maint
    import media_maint_pkg::*;
#(
    parameter int unsigned LBA_W      = 32,
    parameter int unsigned MARK_DEPTH = 8,
    parameter int unsigned FIRST_IDLE = `MS_CYC(`FIRST_IDLE_MS),
    parameter int unsigned LATER_IDLE = `MS_CYC(`LATER_IDLE_MS),
    parameter int unsigned BURST_CYC  = `MS_CYC(`BURST_MS),
    parameter int unsigned PAUSE_CYC  = `MS_CYC(`PAUSE_MS),
    parameter longint unsigned HOUR_CYC = 64'd360000000000
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    host_busy,
    input  wire logic                    cmd_valid,
    input  wire logic                    cmd_write,
    input  wire media_maint_pkg::cdb_len_type cmd_len,
    input  wire logic [2:0]              cmd_guard,
    input  wire logic [LBA_W-1:0]        cmd_lba,
    input  wire logic                    cmd_tlimit,
    output logic                         cmd_done,
    output logic                         cmd_reject,
    output logic                         cmd_verify,
    output logic                         cmd_guard_xfer,
    output logic                         cmd_guard_gen,
    output logic                         cmd_prev_fail,
    input  wire logic                    fmt_valid,
    input  wire logic [7:0]              fmt_byte1,
    output logic                         fmt_erase,
    output media_maint_pkg::guard_type   guard_cur,
    output logic [7:0]                   guard_vpd,
    output logic                         scan_rd_req,
    output logic      [LBA_W-1:0]        scan_lba,
    input  wire logic                    scan_rd_done,
    input  wire logic                    scan_rd_err,
    input  wire logic                    media_recovering,
    input  wire logic                    host_rd_err,
    input  wire logic [LBA_W-1:0]        host_rd_lba,
    output logic                         recheck_req,
    input  wire logic                    recheck_pending,
    input  wire logic                    recheck_mismatch,
    input  wire logic [LBA_W-1:0]        recheck_lba,
    output logic                         rewrite_req,
    output logic      [LBA_W-1:0]        rewrite_lba,
    input  wire logic                    verify_fail,
    output logic                         remap_req
);
    import media_maint_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    scan_state_type   state_r;
    logic [4:0]       ctrl_r;
    logic [LBA_W-1:0] last_lba_r;
    logic [LBA_W-1:0] err_lba_r;
    logic [15:0]      err_count_r;
    logic [31:0]      idle_cnt_r;
    logic [31:0]      phase_cnt_r;
    logic [41:0]      hour_cyc_r;
    logic [4:0]       hours_r;
    logic             first_done_r;
    logic             full_scan_r;
    logic             stop_pend_r;
    logic [LBA_W-1:0] mark_lba_r [MARK_DEPTH];
    logic [MARK_DEPTH-1:0] mark_vld_r;
    logic [$clog2(MARK_DEPTH)-1:0] mark_wp_r;
    logic             apb_wr;
    logic             idle;
    logic             may_realloc;
    logic             hit_any;
    logic [31:0]      start_thr;

    // Block already covered by a scan pass
    function automatic logic covered(input logic [LBA_W-1:0] lba,
                                     input logic [LBA_W-1:0] pos,
                                     input logic full);
        covered = full | (lba < pos);
    endfunction

    // One bit per marked block, set where it matches the given address
    function automatic logic [MARK_DEPTH-1:0] mark_hit(
            input logic [LBA_W-1:0] lba);
        mark_hit = '0;
        for (int i = 0; i < MARK_DEPTH; i++) begin
            mark_hit[i] = mark_vld_r[i] & (mark_lba_r[i] == lba);
        end
    endfunction

    // ------------------------------------------------------------------
    // Idle detection and thresholds
    // ------------------------------------------------------------------
    // Queued and running work both count as busy
    assign idle = ~host_busy & ~cmd_valid;
    assign apb_wr = psel & penable & pready & pwrite;
    assign may_realloc = (ctrl_r[`CTRL_AUTO_WRITE_REALLOCATE_ENABLE] | ctrl_r[`CTRL_AUTO_READ_REALLOCATE_ENABLE])
                         & ~ctrl_r[`CTRL_RC] & ~cmd_tlimit;
    assign hit_any = |mark_hit(cmd_lba);
    // Early-life phase skips the idle delay altogether
    assign start_thr = ctrl_r[`CTRL_PRESCAN] ? 32'h0
                     : (first_done_r ? LATER_IDLE
                                     : FIRST_IDLE);

    // ------------------------------------------------------------------
    // APB slave: answers one cycle after setup, errors on unmapped
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel & ~penable) begin
                case (paddr)
                    `OFS_CTRL:      prdata <= {27'h0, ctrl_r};
                    `OFS_STATUS:    prdata <= {21'h0, hours_r,
                                               guard_cur, state_r,
                                               full_scan_r,
                                               first_done_r};
                    `OFS_SCAN_LBA:  prdata <= 32'(scan_lba);
                    `OFS_LAST_LBA:  prdata <= 32'(last_lba_r);
                    `OFS_ERR_LBA:   prdata <= 32'(err_lba_r);
                    `OFS_ERR_COUNT: prdata <= {16'h0, err_count_r};
                    default: begin
                        prdata  <= 32'h0;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Control register; early-life phase also ends by the hour limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= `CTRL_RESET;
            last_lba_r <= '1;
        end else begin
            if (apb_wr && paddr == `OFS_CTRL)
                ctrl_r <= pwdata[4:0];
            if (apb_wr && paddr == `OFS_LAST_LBA)
                last_lba_r <= pwdata[LBA_W-1:0];
            if (ctrl_r[`CTRL_PRESCAN] && !full_scan_r
                && hours_r == 5'(`PRESCAN_HOURS))
                ctrl_r[`CTRL_PRESCAN] <= 1'b0;
            else if (full_scan_r)
                ctrl_r[`CTRL_PRESCAN] <= 1'b0;
        end
    end

    // Power-on hour count, kept only while it matters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hour_cyc_r <= '0;
            hours_r    <= '0;
        end else if (hours_r != 5'(`PRESCAN_HOURS)) begin
            if (hour_cyc_r == 42'(HOUR_CYC - 1)) begin
                hour_cyc_r <= '0;
                hours_r    <= hours_r + 5'h1;
            end else begin
                hour_cyc_r <= hour_cyc_r + 42'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Scan scheduler
    // ------------------------------------------------------------------
    // Any command restarts the idle timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            idle_cnt_r <= '0;
        else if (!idle)
            idle_cnt_r <= '0;
        else if (idle_cnt_r != 32'hFFFFFFFF)
            idle_cnt_r <= idle_cnt_r + 32'h1;
    end

    // A read already issued is allowed to finish its own recovery
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r      <= ST_WAIT;
            phase_cnt_r  <= '0;
            scan_rd_req  <= 1'b0;
            scan_lba     <= '0;
            first_done_r <= 1'b0;
            full_scan_r  <= 1'b0;
            stop_pend_r  <= 1'b0;
        end else begin
            case (state_r)
                ST_WAIT: begin
                    phase_cnt_r <= '0;
                    if (ctrl_r[`CTRL_SCAN_EN] && idle
                        && idle_cnt_r >= start_thr) begin
                        state_r     <= ST_READ;
                        scan_rd_req <= 1'b1;
                    end
                end
                ST_READ: begin
                    phase_cnt_r <= phase_cnt_r + 32'h1;
                    if (!idle)
                        stop_pend_r <= 1'b1;
                    if ((!idle || stop_pend_r) && !media_recovering) begin
                        scan_rd_req <= 1'b0;
                        stop_pend_r <= 1'b0;
                        state_r     <= ST_WAIT;
                    end else if (scan_rd_done) begin
                        if (scan_lba == last_lba_r) begin
                            scan_lba     <= '0;
                            first_done_r <= 1'b1;
                            full_scan_r  <= 1'b1;
                        end else begin
                            scan_lba <= scan_lba + 1'b1;
                        end
                        if (phase_cnt_r >= BURST_CYC - 1) begin
                            scan_rd_req <= 1'b0;
                            phase_cnt_r <= '0;
                            state_r     <= ST_PAUSE;
                        end
                    end
                end
                ST_PAUSE: begin
                    phase_cnt_r <= phase_cnt_r + 32'h1;
                    if (!idle) begin
                        state_r <= ST_WAIT;
                    end else if (phase_cnt_r >= PAUSE_CYC - 1) begin
                        phase_cnt_r <= '0;
                        scan_rd_req <= ctrl_r[`CTRL_SCAN_EN];
                        state_r     <= ctrl_r[`CTRL_SCAN_EN]
                                       ? ST_READ : ST_WAIT;
                    end
                end
                default: begin
                    state_r     <= ST_WAIT;
                    scan_rd_req <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Error log and deferred reallocation marks
    // ------------------------------------------------------------------
    // Oldest mark is overwritten when the list is full
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_lba_r   <= '0;
            err_count_r <= '0;
            mark_vld_r  <= '0;
            mark_wp_r   <= '0;
            for (int i = 0; i < MARK_DEPTH; i++)
                mark_lba_r[i] <= '0;
        end else begin
            if (cmd_valid && cmd_write && may_realloc)
                mark_vld_r <= mark_vld_r & ~mark_hit(cmd_lba);
            if (state_r == ST_READ && scan_rd_done && scan_rd_err) begin
                err_lba_r   <= scan_lba;
                err_count_r <= err_count_r + 16'h1;
            end
            if (host_rd_err || (scan_rd_done && scan_rd_err)) begin
                mark_lba_r[mark_wp_r] <= host_rd_err ? host_rd_lba
                                                     : scan_lba;
                mark_vld_r[mark_wp_r] <= 1'b1;
                mark_wp_r <= mark_wp_r + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Command checks: guard type rules, verify, deferred reallocation
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_done       <= 1'b0;
            cmd_reject     <= 1'b0;
            cmd_verify     <= 1'b0;
            cmd_guard_xfer <= 1'b0;
            cmd_guard_gen  <= 1'b0;
            cmd_prev_fail  <= 1'b0;
        end else begin
            cmd_done       <= cmd_valid;
            cmd_reject     <= 1'b0;
            cmd_verify     <= 1'b0;
            cmd_guard_xfer <= 1'b0;
            cmd_guard_gen  <= 1'b0;
            cmd_prev_fail  <= 1'b0;
            if (cmd_valid) begin
                case (guard_cur)
                    GUARD_TYPE1: begin
                        cmd_reject     <= (cmd_len == CDB_32);
                        cmd_guard_xfer <= (cmd_len != CDB_32)
                                          && cmd_guard != 3'h0;
                        cmd_guard_gen  <= (cmd_len != CDB_32);
                    end
                    GUARD_TYPE2: begin
                        // Short commands only with a zero guard field
                        cmd_reject     <= (cmd_len != CDB_32)
                                          && cmd_guard != 3'h0;
                        cmd_guard_xfer <= (cmd_len == CDB_32)
                                          && cmd_guard != 3'h0;
                        // A refused command stores nothing
                        cmd_guard_gen  <= (cmd_len == CDB_32)
                                          || cmd_guard == 3'h0;
                    end
                    default: begin
                        cmd_reject <= (cmd_len == CDB_32)
                                      || cmd_guard != 3'h0;
                    end
                endcase
                if (cmd_write) begin
                    cmd_verify <= ctrl_r[`CTRL_PRESCAN]
                        && !covered(cmd_lba, scan_lba, full_scan_r);
                    cmd_prev_fail <= hit_any && !may_realloc;
                end
            end
        end
    end

    // Rewrite in place on marked writes and recheck mismatches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rewrite_req <= 1'b0;
            rewrite_lba <= '0;
            remap_req   <= 1'b0;
            recheck_req <= 1'b0;
        end else begin
            rewrite_req <= 1'b0;
            remap_req   <= verify_fail;
            // Recheck only in idle gaps when no scan read is active
            recheck_req <= idle && recheck_pending
                           && state_r != ST_READ;
            if (cmd_valid && cmd_write && hit_any && may_realloc) begin
                rewrite_req <= 1'b1;
                rewrite_lba <= cmd_lba;
            end else if (recheck_mismatch) begin
                rewrite_req <= 1'b1;
                rewrite_lba <= recheck_lba;
            end
        end
    end

    // ------------------------------------------------------------------
    // Guard format: one type at a time, change erases the medium
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            guard_cur <= GUARD_NONE;
            fmt_erase <= 1'b0;
            guard_vpd <= `VPD_GUARD;
        end else begin
            fmt_erase <= fmt_valid;
            if (fmt_valid) begin
                case (fmt_byte1)
                    `FMT_TYPE1: guard_cur <= GUARD_TYPE1;
                    `FMT_TYPE2: guard_cur <= GUARD_TYPE2;
                    default:    guard_cur <= GUARD_NONE;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// File: media_maint_consts.svh
// Offsets, field positions, reset values and timing counts of the
// background media maintenance block.
// Assumes a 100 MHz pclk; long counts are overridable module parameters.
`ifndef MEDIA_MAINT_CONSTS_SVH
`define MEDIA_MAINT_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL      12'h000
`define OFS_STATUS    12'h004
`define OFS_SCAN_LBA  12'h008
`define OFS_LAST_LBA  12'h00C
`define OFS_ERR_LBA   12'h010
`define OFS_ERR_COUNT 12'h014

// ----------------------------------------------------------------------
// Control fields and reset value
// ----------------------------------------------------------------------
`define CTRL_AUTO_WRITE_REALLOCATE_ENABLE     0
`define CTRL_AUTO_READ_REALLOCATE_ENABLE     1
`define CTRL_RC       2
`define CTRL_PRESCAN  3
`define CTRL_SCAN_EN  4
`define CTRL_RESET    5'h1B

// ----------------------------------------------------------------------
// Timing, as printed, and clock rate
// ----------------------------------------------------------------------
`define CLK_HZ        100000000
`define FIRST_IDLE_MS 5
`define LATER_IDLE_MS 500
`define BURST_MS      800
`define PAUSE_MS      100
`define PRESCAN_HOURS 24
`define MS_CYC(ms)    ((ms) * (`CLK_HZ / 1000))

// ----------------------------------------------------------------------
// Sector format and guard encodings
// ----------------------------------------------------------------------
`define USER_BYTES    512
`define GUARD_BYTES   8
`define SECTOR_BYTES  (`USER_BYTES + `GUARD_BYTES)
`define FMT_TYPE1     8'h90
`define FMT_TYPE2     8'hD0
`define VPD_GUARD     8'h86

`endif

// File: media_maint_pkg.sv
// Types shared by the background media maintenance block.
// Assumes nothing beyond a SystemVerilog compiler.
package media_maint_pkg;

    // Scan scheduler states
    typedef enum logic [1:0] {
        ST_WAIT  = 2'b00,
        ST_READ  = 2'b01,
        ST_PAUSE = 2'b10
    } scan_state_type;

    // Protection format of the medium; type 3 is never entered
    typedef enum logic [1:0] {
        GUARD_NONE  = 2'b00,
        GUARD_TYPE1 = 2'b01,
        GUARD_TYPE2 = 2'b10
    } guard_type;

    // Command block length
    typedef enum logic [1:0] {
        CDB_10 = 2'b00,
        CDB_16 = 2'b01,
        CDB_32 = 2'b10
    } cdb_len_type;

endpackage

// File: media_maint_monitor.sv
// Port checker for the background media maintenance block.
// Assumes one pclk domain and an active-low asynchronous presetn.
`timescale 1ns/1ns
`default_nettype none
module media_maint_monitor (
    input wire logic pclk, presetn, psel, penable, pready,
    input wire logic host_busy, cmd_valid, cmd_done, cmd_reject,
    input wire media_maint_pkg::cdb_len_type cmd_len,
    input wire logic [2:0] cmd_guard,
    input wire media_maint_pkg::guard_type guard_cur,
    input wire logic [7:0] guard_vpd,
    input wire logic scan_rd_req, media_recovering, verify_fail, remap_req
);
    import media_maint_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------------------------------
    // Sequences and properties
    // ----------------------------------------------------------------
    sequence setup_s; psel && !penable; endsequence
    sequence t2_bad_s;
        cmd_valid && guard_cur == GUARD_TYPE2 && cmd_len != CDB_32
            && cmd_guard != 3'h0;
    endsequence
    apb_ready_a: assert property (setup_s |=> pready)
        else $error("apb answer missing");
    apb_pulse_a: assert property (pready |=> !pready)
        else $error("apb ready held");
    cmd_answer_a: assert property (cmd_valid |=> cmd_done || cmd_reject)
        else $error("command not answered");
    type1_long_a: assert property (
        cmd_valid && guard_cur == GUARD_TYPE1 && cmd_len == CDB_32
        |=> cmd_reject) else $error("long command taken");
    type2_guard_a: assert property (t2_bad_s |=> cmd_reject)
        else $error("guarded short command taken");
    no_type3_a: assert property (guard_cur != 2'h3)
        else $error("type three entered");
    vpd_page_a: assert property (guard_vpd == 8'h86)
        else $error("guard page wrong");
    scan_yield_a: assert property (
        scan_rd_req && host_busy && !media_recovering |=> !scan_rd_req)
        else $error("scan kept running");
    recov_hold_a: assert property (
        scan_rd_req && host_busy && media_recovering |=> scan_rd_req)
        else $error("recovery cut short");
    scan_idle_a: assert property (
        $rose(scan_rd_req) |-> !$past(host_busy) && !$past(cmd_valid))
        else $error("scan started while busy");
    remap_a: assert property (verify_fail |=> remap_req)
        else $error("remap missing");
endmodule
bind media_maint media_maint_monitor media_maint_monitor_i (.*);
`default_nettype wire

// File: media_host_model.sv
// Host initiator model: issues block commands and format requests.
// Assumes the bench calls its tasks; fields change after a clock edge.
`timescale 1ns/1ns
`default_nettype none
module media_host_model (
    input  wire logic                         pclk,
    output logic                              host_busy, cmd_valid,
    output logic                              cmd_write, cmd_tlimit,
    output media_maint_pkg::cdb_len_type      cmd_len,
    output logic [2:0]                        cmd_guard,
    output logic [31:0]                       cmd_lba,
    output logic                              fmt_valid,
    output logic [7:0]                        fmt_byte1
);
    import media_maint_pkg::*;
    // Every strobe idle until the bench calls a task
    initial begin
        {host_busy, cmd_valid, cmd_write, cmd_tlimit, fmt_valid} = '0;
        {cmd_guard, cmd_lba, fmt_byte1} = '0;
        cmd_len = CDB_10;
    end
    // Busy covers the command until it is answered
    task automatic issue(input logic w, input cdb_len_type l,
                         input logic [2:0] g, input logic [31:0] a);
        @(posedge pclk);
        host_busy <= 1'b1;
        cmd_len <= l;
        {cmd_valid, cmd_write, cmd_guard, cmd_lba} <= {1'b1, w, g, a};
        @(posedge pclk);
        cmd_valid <= 1'b0;
        cmd_lba <= ~a; // Released fields must not keep their value
        @(posedge pclk);
        host_busy <= 1'b0;
    endtask
    // Recovery time limit flag for the commands that follow
    task automatic limit(input logic t);
        cmd_tlimit <= t;
    endtask
    // Parameter byte picks the guard type
    task automatic format(input logic [7:0] b);
        @(posedge pclk);
        {fmt_valid, fmt_byte1} <= {1'b1, b};
        @(posedge pclk);
        {fmt_valid, fmt_byte1} <= {1'b0, ~b};
    endtask
endmodule
`default_nettype wire

// File: background_media_maintenance_tb.sv
// Self-checking bench for the background media maintenance block.
// Assumes the host model and the port checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin \
    n_fail++; $display("MISMATCH t=%0t %s", $time, m); end end
module background_media_maintenance_tb;
    import media_maint_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, scan_rd_done = 1'b0, media_recovering = 1'b0;
    logic verify_fail = 1'b0, host_rd_err = 1'b0, pready, pslverr;
    logic scan_rd_err = 1'b0, recheck_pending = 1'b0, recheck_mismatch = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, host_rd_lba = 32'h0, prdata, scan_lba;
    logic host_busy, cmd_valid, cmd_write, cmd_tlimit, fmt_valid;
    logic cmd_done, cmd_reject, cmd_verify, cmd_guard_xfer, cmd_guard_gen;
    logic cmd_prev_fail, fmt_erase, scan_rd_req, recheck_req;
    logic rewrite_req, remap_req;
    logic [31:0] cmd_lba, rewrite_lba, lba, recheck_lba = 32'h0;
    logic [2:0] cmd_guard;
    logic [7:0] fmt_byte1, guard_vpd;
    cdb_len_type cmd_len;
    guard_type guard_cur;
    logic [32:0] apq[$];
    logic [5:0] cq[$], cgot;
    logic [12:0] e;
    int n_fail = 0, check_count = 0, cyc = 0, n;
    // Type, write, length, guard field, then reject/xfer/gen/verify/rewrite
    const logic [12:0] tbl [8] = '{13'h0A10, 13'h092C, 13'h122C,
        13'h1004, 13'h1150, 13'h0210, 13'h0030, 13'h0402};
    assign cgot = {cmd_prev_fail, cmd_reject, cmd_guard_xfer, cmd_guard_gen,
                   cmd_verify, rewrite_req};
    media_maint #(.FIRST_IDLE(5), .LATER_IDLE(50), .BURST_CYC(40),
        .PAUSE_CYC(10), .HOUR_CYC(64'd20)) media_maint_i (.*);
    media_host_model media_host_model_i (.*);
    always #5 pclk = ~pclk;
    // Hang guard well above the few hundred cycles the tests need
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            wrap_up();
        end
    end
    // Answers are taken at the edge where the master samples them
    always @(posedge pclk) begin
        if (pready === 1'b1)
            `CHK({pslverr, pwrite ? 32'h0 : prdata}, apq.pop_front(), "apb")
        if (cmd_done === 1'b1 || cmd_reject === 1'b1)
            `CHK(cgot, cq.pop_front(), "cmd")
    end
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] x);
        apq.push_back(x);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {psel, penable, pwrite} <= 3'b000;
    endtask
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        void'($urandom(44680));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Control reset value, unmapped refusal, last block round trip
        lba = {16'hFFFF, 16'($urandom)};
        apb(1'b0, 12'h000, 32'h0, 33'h00000001B);
        apb(1'b0, 12'h018, 32'h0, 33'h100000000);
        apb(1'b1, 12'h00C, lba, 33'h000000000);
        apb(1'b0, 12'h00C, 32'h0, {1'b0, lba});
        $display("test registers done");
        // Each guard type formatted, then its command table
        foreach (tbl[i]) begin
            e = tbl[i];
            if (e[12:11] != guard_cur) begin
                media_host_model_i.format(e[12] ? 8'hD0 :
                    (e[11] ? 8'h90 : 8'h00));
                @(posedge pclk);
                `CHK(fmt_erase, 1'b1, "erase")
                @(posedge pclk);
                `CHK(guard_cur, guard_type'(e[12:11]), "guard")
            end
            cq.push_back(e[4:0]);
            media_host_model_i.issue(e[10], cdb_len_type'(e[9:8]), e[7:5],
                $urandom_range(32'hFFFF, 16));
        end
        $display("test guard types done");
        // Idle scan walks upward; a scan read under recovery holds
        n = 0;
        while (scan_rd_req !== 1'b1 && n++ < 100) @(posedge pclk);
        `CHK(scan_lba, 32'h0, "scan start")
        for (int k = 1; k < 4; k++) begin
            {scan_rd_done, scan_rd_err} <= {1'b1, k == 3};
            @(posedge pclk);
            {scan_rd_done, scan_rd_err} <= 2'b00;
            @(posedge pclk);
            `CHK(scan_lba, 32'(k), "scan step")
        end
        media_recovering <= 1'b1;
        cq.push_back(5'h00);
        media_host_model_i.issue(1'b0, CDB_10, 3'h0, 32'h10);
        media_recovering <= 1'b0;
        cq.push_back(5'h00);
        media_host_model_i.issue(1'b0, CDB_10, 3'h0, 32'h11);
        $display("test scan done");
        // Early-life phase lapses; a marked block is rewritten
        while (cyc < 600) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0, 33'h000000013);
        apb(1'b0, 12'h010, 32'h0, 33'h000000002);
        media_host_model_i.limit(1'b1);
        cq.push_back(6'h20);
        media_host_model_i.issue(1'b1, CDB_10, 3'h0, 32'h2);
        media_host_model_i.limit(1'b0);
        lba = $urandom_range(32'hFFFF, 16);
        {host_rd_err, host_rd_lba} <= {1'b1, lba};
        @(posedge pclk);
        host_rd_err <= 1'b0;
        cq.push_back(5'h01);
        media_host_model_i.issue(1'b1, CDB_10, 3'h0, lba);
        {verify_fail, recheck_pending} <= 2'b11;
        @(posedge pclk);
        verify_fail <= 1'b0;
        {recheck_mismatch, recheck_lba} <= {1'b1, ~lba};
        @(posedge pclk);
        recheck_mismatch <= 1'b0;
        `CHK({remap_req, recheck_req}, 2'b11, "remap")
        @(posedge pclk);
        `CHK(rewrite_lba, ~lba, "recheck lba")
        $display("test reallocation done");
        wrap_up();
    end
endmodule
`default_nettype wire
